/* File: bench/mmu_tag_access_pointer_regs_bench.sv */
// Self-checking bench for the fault address, tag and pointer unit
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module mmu_tag_access_pointer_regs_bench import mtp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset_n, am, dbit;
	mtp_reg_req_t req;
	mtp_reg_rsp_t rsp;
	mtp_itrap_t itrap;
	mtp_dtrap_t dtrap;
	logic [63:0] i_tag, d_tag, fa, last;
	logic [10:0] cfgx [4];
	logic [63:0] base [4];
	logic [63:0] tag [2];
	int mismatches, n_tests, seed;

	always #5 clk = ~clk;

	mtp_tag_ptr mtp_tag_ptr_inst (.clk(clk), .reset_n(reset_n),
		.reg_req(req), .reg_rsp(rsp), .itrap(itrap), .dtrap(dtrap),
		.addr_mask_32_mode(am), .i_translation_tag_staging(i_tag),
		.d_translation_tag_staging(d_tag));
	mtp_trap_source mtp_trap_source_inst (.clk(clk), .itrap(itrap),
		.dtrap(dtrap));

	function automatic logic [63:0] sx(input logic [63:0] v);
		return {{16{v[47]}}, v[47:0]};
	endfunction : sx

	function automatic logic [2:0] fx(input logic [2:0] p);
		return (p == 3'h2 || p == 3'h4 || p > 3'h5) ? PS_256M : p;
	endfunction : fx

	function automatic logic [63:0] tgt(input logic [63:0] v);
		logic [63:0] t;
		t = sx(v);
		return {3'h0, t[12:0], 6'h0, t[63:22]};
	endfunction : tgt

	// Candidate entry address; split is kept clear by the stimulus
	function automatic logic [63:0] ptr(input int s, input int b1);
		logic [63:0] t, bs, m;
		logic [10:0] c;
		logic [2:0] ps;
		t = sx(tag[s]);
		bs = base[2 * s + b1];
		c = (tag[s][12:0] == 13'h0) ? cfgx[2 * s] : cfgx[2 * s + 1];
		ps = (b1 == 1) ? c[10:8] : c[2:0];
		m = (64'h1 << (13 + int'(bs[3:0]))) - 64'h1;
		return sx((bs & ~m) | (((t >> (13 + 3 * int'(ps))) << 4) & m));
	endfunction : ptr

	task automatic wr(input logic [4:0] s, input logic [63:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b1, s, d};
		@(posedge clk);
		req.valid <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [4:0] s, input logic [63:0] e);
		@(posedge clk);
		req <= '{1'b1, 1'b0, s, 64'h0};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		`CHK($sformatf("sel %h", s), {1'b1, e}, {rsp.valid, rsp.rdata})
		last = rsp.rdata;
	endtask : rdc

	task automatic chk_side(input int s);
		rdc(s == 1 ? SEL_D_TARGET : SEL_I_TARGET, tgt(tag[s]));
		rdc(s == 1 ? SEL_D_PTR0 : SEL_I_PTR0, ptr(s, 0));
		rdc(s == 1 ? SEL_D_PTR1 : SEL_I_PTR1, ptr(s, 1));
		if (s == 1) begin
			rdc(SEL_D_DIRECT, dbit ? ptr(1, 1) : ptr(1, 0));
		end
	endtask : chk_side

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end

	initial begin
		int k, c, s, b;
		logic [63:0] v, w;
		logic [2:0] p;
		mtp_itrap_t it;
		mtp_dtrap_t dt;
		clk = 1'b0;
		reset_n = 1'b0;
		am = 1'b0;
		req = '0;
		seed = 90094;
		cfgx = '{default: '0};
		base = '{default: '0};
		tag = '{default: '0};
		fa = '0;
		dbit = 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		rdc(SEL_SAVED_PC, 64'h0);
		rdc(5'h1f, 64'h0);
		chk_side(1);
		for (c = 0; c < 8; c++) begin
			w = {$random(seed), $random(seed)};
			w[10:8] = 3'(c);
			w[2:0] = 3'(7 - c);
			cfgx[c % 4] = {fx(w[10:8]), 5'h0, fx(w[2:0])};
			wr(SEL_I_ZCFG + 5'(c % 4), w);
			rdc(SEL_I_ZCFG + 5'(c % 4), 64'(cfgx[c % 4]));
		end
		for (k = 0; k < 40; k++) begin
			s = k % 2;
			b = {$random(seed)} % 2;
			v = {$random(seed), $random(seed)};
			v[12] = 1'b0;
			base[2 * s + b] = v;
			wr(SEL_I_BASE0 + 5'(2 * s + b), v);
			w = {$random(seed), $random(seed)};
			cfgx[2 * s + b] = {fx(w[10:8]), 5'h0, fx(w[2:0])};
			wr(SEL_I_ZCFG + 5'(2 * s + b), w);
			v = {$random(seed), $random(seed)};
			if (b == 1) begin
				v[12:0] = 13'h0;
			end
			tag[s] = v;
			wr(s == 1 ? SEL_D_TAG : SEL_I_TAG, v);
			#1;
			`CHK("raw tag", v, s == 1 ? d_tag : i_tag)
			rdc(s == 1 ? SEL_D_TAG : SEL_I_TAG, sx(v));
			wr(s == 1 ? SEL_D_PTR0 : SEL_I_PTR0, w);
			chk_side(s);
		end
		for (k = 0; k < 16; k++) begin
			it = '0;
			it.kind = mtp_itrap_kind_t'(k % 4);
			it.fetch_va = {$random(seed), $random(seed)};
			it.insn_va = {$random(seed), $random(seed)};
			it.has_ctx = k[2];
			it.ctx = 13'($random(seed));
			if (it.kind == IT_RANGE_SEQ) begin
				it.fetch_va[63:48] = ~{16{it.fetch_va[47]}};
			end
			@(posedge clk);
			am <= k[3];
			v = it.fetch_va;
			if (k[3]) begin
				v[63:32] = 32'h0;
			end
			tag[0] = {v[63:13], it.has_ctx ? it.ctx : 13'h0};
			mtp_trap_source_inst.send_i(it);
			#1;
			`CHK("i tag", tag[0], i_tag)
			w = sx(it.kind == IT_RANGE_JUMP_AND_LINK_INSN ? it.insn_va : it.fetch_va);
			rdc(SEL_SAVED_PC, w);
			if (it.kind == IT_RANGE_SEQ) begin
				`CHK("range", it.fetch_va, last ^ RANGE_XOR_MASK)
			end
			chk_side(0);
		end
		for (k = 0; k < 24; k++) begin
			dt = '0;
			dt.kind = mtp_dtrap_kind_t'(k % 3);
			dt.va = sx({$random(seed), $random(seed)});
			dt.nucleus = k[1];
			dt.has_ctx = k[2] | ~k[1];
			dt.ctx = 13'($random(seed)) | 13'h1;
			p = dt.nucleus ? cfgx[2][10:8] : cfgx[3][10:8];
			dt.hit_ps = k[3] ? p : 3'($random(seed));
			@(posedge clk);
			am <= k[4];
			v = dt.va;
			if (k[4]) begin
				v[63:32] = 32'h0;
			end
			tag[1] = {v[63:13], dt.has_ctx ? dt.ctx : 13'h0};
			if (dt.kind != DT_MISS) begin
				fa = dt.va;
			end
			if (dt.kind == DT_PROTECTION) begin
				dbit = (dt.hit_ps == p);
			end
			mtp_trap_source_inst.send_d(dt);
			#1;
			`CHK("d tag", tag[1], d_tag)
			rdc(SEL_D_FAULT_ADDR, fa);
			chk_side(1);
		end
		report_and_stop();
	end
endmodule : mmu_tag_access_pointer_regs_bench

/* File: bench/mtp_trap_source.sv */
// Pipeline trap source model: one-cycle trap events toward the unit
module mtp_trap_source import mtp_pkg::*; (
	input wire logic clk,
	output mtp_itrap_t itrap,
	output mtp_dtrap_t dtrap
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		itrap = '0;
		dtrap = '0;
	end

	// Returns at the edge that takes the event
	task automatic send_i(input mtp_itrap_t t);
		t.valid = 1'b1;
		@(posedge clk);
		itrap <= t;
		@(posedge clk);
		itrap.valid <= 1'b0;
	endtask : send_i

	task automatic send_d(input mtp_dtrap_t t);
		t.valid = 1'b1;
		@(posedge clk);
		dtrap <= t;
		@(posedge clk);
		dtrap.valid <= 1'b0;
	endtask : send_d
endmodule : mtp_trap_source

/* File: src/mtp_pkg.sv */
// Shared constants, carrier types and helper functions of the tag unit
//
// Overview of operation
// - No instruction fault address register; saved trap pc serves instead.
// - On an instruction miss trap the saved pc holds the missed address.
// - On a privilege fetch fault the saved pc holds the privileged address.
// - Range fetch faults keep 48 address bits; reads sign-extend bit 47.
// - Jump-and-link or return range faults save that instruction's address.
// - Data fault address follows the fault recorded in the data fault status.
// - Any translation trap loads the tag register with page and context.
// - Tag updates show at once in tag target and pointer reads.
// - With 32-bit address mask set, trap-loaded tag upper 32 bits are zero; saved pc and fault address are unmasked.
// - Tag register bits 63:13 hold the 51-bit virtual page number.
// - Tag bits 12:0 hold the context; zero when the access has none.
// - Tag stores are not range-checked; reads sign-extend from bit 47.
// - Pointers use zero-context sizes for context zero, else nonzero ones.
// - Direct pointer returns second-size pointer if trap entry matched it.
// - Pointers are combinational from current tag and base registers.
// - A data-side bit records second-size hits on each protection trap.
// - That bit compares nucleus accesses to zero config, others to nonzero.
// - Pointer reads return a full 64-bit address sign-extended from bit 47.
// - Unsupported page sizes written to a config field become 256 MB.
package mtp_pkg;

	localparam int VPN_LSB = 13;
	localparam int SEXT_BIT = 47;
	localparam int CTX_W = 13;
	localparam int SAVED_PC_W = 48;
	localparam int PS1_LSB = 8;
	localparam int PS0_LSB = 0;
	localparam int SPLIT_BIT = 12;
	localparam int TTE_SHIFT = 4;
	localparam int TSB_BYTES_LOG = 13;
	localparam int TARGET_CTX_LSB = 48;
	localparam int TARGET_VA_LSB = 22;
	localparam int CFG_W = 11;
	localparam logic [2:0] PS_8K = 3'h0;
	localparam logic [2:0] PS_64K = 3'h1;
	localparam logic [2:0] PS_4M = 3'h3;
	localparam logic [2:0] PS_256M = 3'h5;
	localparam logic [63:0] RANGE_XOR_MASK = 64'hffff_0000_0000_0000;
	localparam logic [63:0] RST_REG64 = 64'h0;
	localparam logic [10:0] RST_CFG = 11'h0;

	// Register selects carried on the alternate-space access port
	localparam logic [4:0] SEL_SAVED_PC = 5'h00;
	localparam logic [4:0] SEL_D_FAULT_ADDR = 5'h01;
	localparam logic [4:0] SEL_I_TAG = 5'h02;
	localparam logic [4:0] SEL_D_TAG = 5'h03;
	localparam logic [4:0] SEL_I_TARGET = 5'h04;
	localparam logic [4:0] SEL_D_TARGET = 5'h05;
	localparam logic [4:0] SEL_I_ZCFG = 5'h06;
	localparam logic [4:0] SEL_I_NZCFG = 5'h07;
	localparam logic [4:0] SEL_D_ZCFG = 5'h08;
	localparam logic [4:0] SEL_D_NZCFG = 5'h09;
	localparam logic [4:0] SEL_I_BASE0 = 5'h0a;
	localparam logic [4:0] SEL_I_BASE1 = 5'h0b;
	localparam logic [4:0] SEL_D_BASE0 = 5'h0c;
	localparam logic [4:0] SEL_D_BASE1 = 5'h0d;
	localparam logic [4:0] SEL_I_PTR0 = 5'h0e;
	localparam logic [4:0] SEL_I_PTR1 = 5'h0f;
	localparam logic [4:0] SEL_D_PTR0 = 5'h10;
	localparam logic [4:0] SEL_D_PTR1 = 5'h11;
	localparam logic [4:0] SEL_D_DIRECT = 5'h12;

	typedef enum logic [1:0] {
		IT_MISS, IT_PRIV, IT_RANGE_SEQ, IT_RANGE_JUMP_AND_LINK_INSN
	} mtp_itrap_kind_t;

	typedef enum logic [1:0] {
		DT_MISS, DT_EXCEPTION, DT_PROTECTION
	} mtp_dtrap_kind_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] sel;
		logic [63:0] wdata;
	} mtp_reg_req_t;

	typedef struct packed {
		logic valid;
		logic [63:0] rdata;
	} mtp_reg_rsp_t;

	typedef struct packed {
		logic valid;
		mtp_itrap_kind_t kind;
		logic [63:0] fetch_va;
		logic [63:0] insn_va;
		logic has_ctx;
		logic [12:0] ctx;
	} mtp_itrap_t;

	typedef struct packed {
		logic valid;
		mtp_dtrap_kind_t kind;
		logic [63:0] va;
		logic has_ctx;
		logic [12:0] ctx;
		logic nucleus;
		logic [2:0] hit_ps;
	} mtp_dtrap_t;

	typedef struct packed {
		logic [47:0] saved_pc;
		logic [63:0] fault_addr;
		logic [1:0][63:0] tag;
		logic [1:0][10:0] zcfg;
		logic [1:0][10:0] nzcfg;
		logic [3:0][63:0] base;
		logic direct_ps1;
		mtp_reg_rsp_t rsp;
	} mtp_state_t;

	function automatic logic [63:0] mtp_sext47(input logic [63:0] v);
		mtp_sext47 = {{(63 - SEXT_BIT){v[SEXT_BIT]}}, v[SEXT_BIT:0]};
	endfunction : mtp_sext47

	function automatic logic [2:0] mtp_fix_ps(input logic [2:0] ps);
		if (ps == PS_8K || ps == PS_64K || ps == PS_4M || ps == PS_256M) begin
			mtp_fix_ps = ps;
		end else begin
			mtp_fix_ps = PS_256M;
		end
	endfunction : mtp_fix_ps

	function automatic logic [5:0] mtp_ps_shift(input logic [2:0] ps);
		mtp_ps_shift = 6'(VPN_LSB) + 6'(3 * int'(ps));
	endfunction : mtp_ps_shift

	function automatic logic [63:0] mtp_target(input logic [63:0] tag);
		logic [63:0] t;
		t = mtp_sext47(tag);
		mtp_target = {3'h0, t[CTX_W-1:0], 6'h0, t[63:TARGET_VA_LSB]};
	endfunction : mtp_target

endpackage : mtp_pkg

/* File: src/mtp_ptr_calc.sv */
// Table-entry pointer formation from tag and buffer base contents
module mtp_ptr_calc import mtp_pkg::*; (
	input wire logic [63:0] tag,
	input wire logic [63:0] base,
	input wire logic [2:0] ps,
	input wire logic is_ps1,
	output logic [63:0] ptr
);
	logic [5:0] shift;
	logic [5:0] tsb_log;
	logic split;
	logic [63:0] va;
	logic [63:0] off;
	logic [63:0] mask;

	assign split = base[SPLIT_BIT];
	assign shift = mtp_ps_shift(ps);
	assign tsb_log = 6'(TSB_BYTES_LOG) + {2'h0, base[3:0]};
	assign va = mtp_sext47(tag);
	// Split buffers place the second-size half just above the first
	assign off = ((va >> shift) << TTE_SHIFT)
		| ((split && is_ps1) ? (64'h1 << tsb_log) : 64'h0);
	assign mask = (64'h1 << (tsb_log + {5'h0, split})) - 64'h1;
	// Pure rearrangement of live register contents
	assign ptr = mtp_sext47((base & ~mask) | (off & mask));
endmodule : mtp_ptr_calc

/* File: src/mtp_tag_ptr.sv */
// Fault address, tag staging and table-entry pointer registers
module mtp_tag_ptr import mtp_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire mtp_reg_req_t reg_req,
	output mtp_reg_rsp_t reg_rsp,
	input wire mtp_itrap_t itrap,
	input wire mtp_dtrap_t dtrap,
	input wire logic addr_mask_32_mode,
	output logic [63:0] i_translation_tag_staging,
	output logic [63:0] d_translation_tag_staging
);
	mtp_state_t state;
	mtp_state_t next_state;
	logic [3:0][2:0] ptr_ps;
	logic [3:0][63:0] table_entry_pointer;
	logic [63:0] direct_ptr;
	logic [63:0] i_trap_tag;
	logic [63:0] d_trap_tag;

	// Index 0/1: instruction first/second size, 2/3: data first/second size
	for (genvar g = 0; g < 4; g++) begin : g_ptr
		// Size source follows the staged context
		assign ptr_ps[g] = (state.tag[g/2][CTX_W-1:0] == '0)
			? state.zcfg[g/2][PS1_LSB*(g%2) +: 3]
			: state.nzcfg[g/2][PS1_LSB*(g%2) +: 3];
		mtp_ptr_calc u_ptr (
			.tag(state.tag[g/2]),
			.base(state.base[g]),
			.ps(ptr_ps[g]),
			.is_ps1(1'(g % 2)),
			.ptr(table_entry_pointer[g])
		);
	end

	// Direct pointer chosen by the recorded hit size
	assign direct_ptr = state.direct_ps1 ? table_entry_pointer[3]
		: table_entry_pointer[2];

	// Trap-time tag: page number plus context, masked in 32-bit mode
	function automatic logic [63:0] trap_tag(input logic [63:0] va,
			input logic has_ctx, input logic [12:0] ctx, input logic am);
		logic [63:0] v;
		v = am ? {32'h0, va[31:0]} : va;
		trap_tag = {v[63:VPN_LSB], has_ctx ? ctx : 13'h0};
	endfunction : trap_tag

	assign i_trap_tag = trap_tag(itrap.fetch_va, itrap.has_ctx, itrap.ctx,
		addr_mask_32_mode);
	assign d_trap_tag = trap_tag(dtrap.va, dtrap.has_ctx, dtrap.ctx,
		addr_mask_32_mode);

	always_comb begin
		logic wr;
		logic [63:0] rd;
		logic [10:0] cfg_w;
		wr = reg_req.valid && reg_req.write;
		rd = 64'h0;
		cfg_w = {mtp_fix_ps(reg_req.wdata[PS1_LSB +: 3]), 5'h0,
			mtp_fix_ps(reg_req.wdata[PS0_LSB +: 3])};
		next_state = state;

		// Software stores; hardware trap updates below take priority
		if (wr) begin
			case (reg_req.sel)
			SEL_SAVED_PC: begin
				next_state.saved_pc = reg_req.wdata[SAVED_PC_W-1:0];
			end
			SEL_D_FAULT_ADDR: begin
				next_state.fault_addr = reg_req.wdata;
			end
			SEL_I_TAG: begin
				next_state.tag[0] = reg_req.wdata;
			end
			SEL_D_TAG: begin
				next_state.tag[1] = reg_req.wdata;
			end
			SEL_I_ZCFG: begin
				next_state.zcfg[0] = cfg_w;
			end
			SEL_I_NZCFG: begin
				next_state.nzcfg[0] = cfg_w;
			end
			SEL_D_ZCFG: begin
				next_state.zcfg[1] = cfg_w;
			end
			SEL_D_NZCFG: begin
				next_state.nzcfg[1] = cfg_w;
			end
			SEL_I_BASE0: begin
				next_state.base[0] = reg_req.wdata;
			end
			SEL_I_BASE1: begin
				next_state.base[1] = reg_req.wdata;
			end
			SEL_D_BASE0: begin
				next_state.base[2] = reg_req.wdata;
			end
			SEL_D_BASE1: begin
				next_state.base[3] = reg_req.wdata;
			end
			default: begin
			end
			endcase
		end

		// Instruction traps: no separate fault address, saved pc instead
		if (itrap.valid) begin
			unique case (itrap.kind)
			IT_MISS: begin
				next_state.saved_pc = itrap.fetch_va[SAVED_PC_W-1:0];
			end
			IT_PRIV: begin
				next_state.saved_pc = itrap.fetch_va[SAVED_PC_W-1:0];
			end
			IT_RANGE_SEQ: begin
				next_state.saved_pc = itrap.fetch_va[SAVED_PC_W-1:0];
			end
			IT_RANGE_JUMP_AND_LINK_INSN: begin
				next_state.saved_pc = itrap.insn_va[SAVED_PC_W-1:0];
			end
			endcase
			next_state.tag[0] = i_trap_tag;
		end

		// Data traps: miss leaves the fault address alone
		if (dtrap.valid) begin
			next_state.tag[1] = d_trap_tag;
			if (dtrap.kind != DT_MISS) begin
				next_state.fault_addr = dtrap.va;
			end
			if (dtrap.kind == DT_PROTECTION) begin
				// Nucleus compares to zero config even if context is zero
				next_state.direct_ps1 = dtrap.hit_ps == (dtrap.nucleus
					? state.zcfg[1][PS1_LSB +: 3]
					: state.nzcfg[1][PS1_LSB +: 3]);
			end
		end

		// Reads see current contents; pointers follow them at once
		case (reg_req.sel)
		SEL_SAVED_PC: begin
			rd = mtp_sext47({16'h0, state.saved_pc});
		end
		SEL_D_FAULT_ADDR: begin
			rd = state.fault_addr;
		end
		SEL_I_TAG: begin
			rd = mtp_sext47(state.tag[0]);
		end
		SEL_D_TAG: begin
			rd = mtp_sext47(state.tag[1]);
		end
		SEL_I_TARGET: begin
			rd = mtp_target(state.tag[0]);
		end
		SEL_D_TARGET: begin
			rd = mtp_target(state.tag[1]);
		end
		SEL_I_ZCFG: begin
			rd = {53'h0, state.zcfg[0]};
		end
		SEL_I_NZCFG: begin
			rd = {53'h0, state.nzcfg[0]};
		end
		SEL_D_ZCFG: begin
			rd = {53'h0, state.zcfg[1]};
		end
		SEL_D_NZCFG: begin
			rd = {53'h0, state.nzcfg[1]};
		end
		SEL_I_BASE0: begin
			rd = state.base[0];
		end
		SEL_I_BASE1: begin
			rd = state.base[1];
		end
		SEL_D_BASE0: begin
			rd = state.base[2];
		end
		SEL_D_BASE1: begin
			rd = state.base[3];
		end
		SEL_I_PTR0: begin
			rd = table_entry_pointer[0];
		end
		SEL_I_PTR1: begin
			rd = table_entry_pointer[1];
		end
		SEL_D_PTR0: begin
			rd = table_entry_pointer[2];
		end
		SEL_D_PTR1: begin
			rd = table_entry_pointer[3];
		end
		SEL_D_DIRECT: begin
			rd = direct_ptr;
		end
		default: begin
			rd = 64'h0;
		end
		endcase
		next_state.rsp.valid = reg_req.valid && !reg_req.write;
		next_state.rsp.rdata = (reg_req.valid && !reg_req.write) ? rd : 64'h0;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state.saved_pc <= RST_REG64[SAVED_PC_W-1:0];
			state.fault_addr <= RST_REG64;
			state.tag <= {2{RST_REG64}};
			state.zcfg <= {2{RST_CFG}};
			state.nzcfg <= {2{RST_CFG}};
			state.base <= {4{RST_REG64}};
			state.direct_ps1 <= 1'b0;
			state.rsp <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rsp = state.rsp;
	// Entry-write logic takes its tag from the staged value
	assign i_translation_tag_staging = state.tag[0];
	assign d_translation_tag_staging = state.tag[1];

	a_miss_saves_pc: assert property (@(posedge clk)
		disable iff (!reset_n)
		itrap.valid && itrap.kind == IT_MISS
		|=> state.saved_pc == $past(itrap.fetch_va[47:0]))
		else $error("saved pc not loaded on miss");

	a_priv_saves_pc: assert property (@(posedge clk)
		disable iff (!reset_n)
		itrap.valid && itrap.kind == IT_PRIV
		|=> state.saved_pc == $past(itrap.fetch_va[47:0]))
		else $error("saved pc not loaded on privilege fault");

	a_jump_and_link_insn_saves_insn: assert property (@(posedge clk)
		disable iff (!reset_n)
		itrap.valid && itrap.kind == IT_RANGE_JUMP_AND_LINK_INSN
		|=> state.saved_pc == $past(itrap.insn_va[47:0]))
		else $error("jump range fault saved wrong pc");

	a_pc_read_sext: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && !reg_req.write && reg_req.sel == SEL_SAVED_PC
		##1 1'b1 |-> reg_rsp.valid
		&& reg_rsp.rdata == {{16{$past(state.saved_pc[47])}},
		$past(state.saved_pc)})
		else $error("saved pc read not sign-extended");

	a_fault_addr_load: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && dtrap.kind != DT_MISS
		|=> state.fault_addr == $past(dtrap.va))
		else $error("fault address not captured");

	a_am_upper_zero: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && addr_mask_32_mode |=> state.tag[1][63:32] == 32'h0)
		else $error("tag upper half not cleared in 32-bit mode");

	a_no_ctx_zero: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && !dtrap.has_ctx |=> state.tag[1][12:0] == 13'h0)
		else $error("tag context not zero without context");

	a_cfg_ps_legal: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && reg_req.write && reg_req.sel == SEL_D_ZCFG
		&& reg_req.wdata[10:8] inside {3'h2, 3'h4, 3'h6, 3'h7}
		|=> state.zcfg[1][10:8] == PS_256M)
		else $error("unsupported page size kept");

	a_direct_follows: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && !reg_req.write && reg_req.sel == SEL_D_DIRECT
		|=> reg_rsp.rdata == ($past(state.direct_ps1)
		? $past(table_entry_pointer[3]) : $past(table_entry_pointer[2])))
		else $error("direct pointer picked wrong size");

	a_tag_tracks_trap: assert property (@(posedge clk)
		disable iff (!reset_n)
		itrap.valid && !addr_mask_32_mode
		|=> state.tag[0][63:13] == $past(itrap.fetch_va[63:13]))
		else $error("instruction tag not loaded on trap");

	a_seq_range_pc: assert property (@(posedge clk)
		disable iff (!reset_n)
		itrap.valid && itrap.kind == IT_RANGE_SEQ
		|=> state.saved_pc == $past(itrap.fetch_va[47:0]))
		else $error("range fault saved wrong pc");

	a_tag_store_raw: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && reg_req.write && reg_req.sel == SEL_I_TAG
		&& !itrap.valid |=> state.tag[0] == $past(reg_req.wdata))
		else $error("tag store altered on the way in");

	a_tag_read_sext: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && !reg_req.write && reg_req.sel == SEL_D_TAG
		|=> reg_rsp.rdata == {{16{$past(state.tag[1][47])}},
		$past(state.tag[1][47:0])})
		else $error("tag read not sign-extended");

	a_dtag_tracks_trap: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && !addr_mask_32_mode
		|=> state.tag[1][63:13] == $past(dtrap.va[63:13]))
		else $error("data tag page not loaded on trap");

	a_ictx_loaded: assert property (@(posedge clk)
		disable iff (!reset_n)
		itrap.valid && itrap.has_ctx
		|=> state.tag[0][12:0] == $past(itrap.ctx))
		else $error("instruction tag context not loaded");

	a_miss_keeps_fault: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && dtrap.kind == DT_MISS
		&& !(reg_req.valid && reg_req.write && reg_req.sel == SEL_D_FAULT_ADDR)
		|=> state.fault_addr == $past(state.fault_addr))
		else $error("miss changed fault address");

	a_direct_bit_set: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && dtrap.kind == DT_PROTECTION && dtrap.nucleus
		|=> state.direct_ps1
		== ($past(dtrap.hit_ps) == $past(state.zcfg[1][10:8])))
		else $error("direct bit ignores zero config on nucleus");

	a_direct_bit_user: assert property (@(posedge clk)
		disable iff (!reset_n)
		dtrap.valid && dtrap.kind == DT_PROTECTION && !dtrap.nucleus
		|=> state.direct_ps1
		== ($past(dtrap.hit_ps) == $past(state.nzcfg[1][10:8])))
		else $error("direct bit ignores nonzero config");

	a_target_live: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && !reg_req.write && reg_req.sel == SEL_I_TARGET
		|=> reg_rsp.rdata[41:0] == {{16{$past(state.tag[0][47])}},
		$past(state.tag[0][47:22])}
		&& reg_rsp.rdata[60:48] == $past(state.tag[0][12:0]))
		else $error("tag target not from current tag");

	a_ptr_read_sext: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && !reg_req.write && reg_req.sel == SEL_D_PTR0
		|=> reg_rsp.rdata[63:48] == {16{reg_rsp.rdata[47]}})
		else $error("pointer read not sign-extended");

	a_cfg_ps0_legal: assert property (@(posedge clk)
		disable iff (!reset_n)
		reg_req.valid && reg_req.write && reg_req.sel == SEL_I_NZCFG
		&& reg_req.wdata[2:0] inside {3'h2, 3'h4, 3'h6, 3'h7}
		|=> state.nzcfg[0][2:0] == PS_256M)
		else $error("unsupported first page size kept");
endmodule : mtp_tag_ptr
